// ===== ffsp_pkg.sv
// constants and types for the fifo and flexible serial slave port
package ffsp_pkg;
    // clock rates in MHz
    localparam int CLK_MHZ = 200;
    localparam int FCLK_MHZ = 60;
    // phase accumulator for the driven fifo clock, two toggles per period
    localparam logic [8:0] FCLK_STEP = 9'(2 * FCLK_MHZ);
    localparam logic [8:0] FCLK_WRAP = 9'(CLK_MHZ);

    // apb register byte offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;

    // control register fields
    localparam int CTRL_SYNC_POS = 0;
    localparam int CTRL_STEN_POS = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;

    // status register fields
    localparam int STAT_MODE_POS = 0;
    localparam int STAT_WID_POS = 4;
    localparam int STAT_CMD_POS = 6;
    localparam int STAT_SEL_POS = 10;
    localparam int STAT_RXE_POS = 11;
    localparam int STAT_TXF_POS = 12;

    // non-volatile mode strap codes
    localparam logic [1:0] NV_OTHER = 2'h0;
    localparam logic [1:0] NV_ASYNC = 2'h1;
    localparam logic [1:0] NV_FLEX = 2'h2;

    // idle levels of {oe_n, wr_n, rd_n, ss_n, sclk}
    localparam logic [4:0] PIN_RST = 5'h1e;
    localparam logic [7:0] DATA_RST = 8'hff;

    // serial bus width codes, lanes = 1 << code
    localparam logic [1:0] W1 = 2'h0;
    localparam logic [1:0] W2 = 2'h1;
    localparam logic [1:0] W4 = 2'h2;
    localparam logic [1:0] W8 = 2'h3;

    // command bit positions inside the command word, msb first
    localparam int CMD3_POS = 0;
    localparam int CMD2_POS = 3;
    localparam int CMD1_POS = 5;
    localparam int CMD0_POS = 6;
    localparam logic [3:0] CMD_WRITE = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h1;

    localparam logic ACK_LVL = 1'b0;
    localparam logic NAK_LVL = 1'b1;

    typedef enum logic [3:0] {
        FFSP_MODE_OFF = 4'h1,
        FFSP_MODE_ASYNC = 4'h2,
        FFSP_MODE_SYNC = 4'h4,
        FFSP_MODE_FLEX = 4'h8
    } ffsp_mode_t;

    typedef enum logic [3:0] {
        FFSP_F_IDLE = 4'h1,
        FFSP_F_CMD = 4'h2,
        FFSP_F_TURN = 4'h4,
        FFSP_F_DATA = 4'h8
    } ffsp_fst_t;
endpackage : ffsp_pkg

// ===== ffsp_sync.sv
// three flop input synchroniser with agreement filter
`timescale 1ns/1ps
module ffsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    // a bit moves only once the second and third stage agree
    assign q_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_q);
    assign q = q_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            q_q <= RST;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= q_d;
        end
    end
endmodule : ffsp_sync

// ===== ffsp_port.sv
// fifo and flexible serial slave port with apb control
// What this block does
// - sync fifo: read or write, never both
// - sync transfers happen on fifo clock rise
// - drive fifo clock at 60 MHz in sync mode
// - sync mode only over async strap
// - rx available low while receive data held
// - output enable before read strobe, then data
// - held read strobe bursts, next byte follows
// - rx available high when data exhausted
// - write taken when space and strobe low
// - async mode moves bytes on strobe falls
// - async mode: no clock out, no enable
// - flex mode: half-duplex slave, 1-8 lanes
// - deselected: tx status line0, rx status line
// - option to stop deselected status drive
// - command phase then data, ack per byte
// - width coded on first edge after select
// - width decode by priority, 8 then 4,2,1
// - pulled-up lines read one for decode
// - four command bits at 0,3,5,6
// - 1-bit: seven command clocks, turnaround, 8/byte
// - select active stops line0 drive at once
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ffsp_port (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] nv_mode,
    input wire logic rxb_valid,
    input wire logic [7:0] rxb_data,
    output logic rxb_ready,
    output logic txb_valid,
    output logic [7:0] txb_data,
    input wire logic txb_ready,
    input wire logic [7:0] bidir_data_lines_i,
    output logic [7:0] bidir_data_lines_o,
    output logic [7:0] bidir_data_lines_oe,
    output logic rx_data_available_n,
    output logic tx_space_available_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    output logic fifo_clock_out,
    input wire logic serial_clock,
    input wire logic slave_select_n,
    output logic status_line_o,
    output logic status_line_oe
);
    function automatic logic [7:0] ffsp_lanes(input logic [1:0] w);
        unique case (w)
            ffsp_pkg::W1: ffsp_lanes = 8'h01;
            ffsp_pkg::W2: ffsp_lanes = 8'h03;
            ffsp_pkg::W4: ffsp_lanes = 8'h0f;
            default: ffsp_lanes = 8'hff;
        endcase
    endfunction : ffsp_lanes

    // pin synchronisers
    logic [4:0] ctl_s;
    logic [7:0] dat_s;
    ffsp_sync #(.W(5), .RST(ffsp_pkg::PIN_RST)) u_ctl_sync (
        .clock(clock),
        .rstn(rstn),
        .d({output_enable_n, write_strobe_n, read_strobe_n, slave_select_n, serial_clock}),
        .q(ctl_s)
    );
    ffsp_sync #(.W(8), .RST(ffsp_pkg::DATA_RST)) u_dat_sync (
        .clock(clock),
        .rstn(rstn),
        .d(bidir_data_lines_i),
        .q(dat_s)
    );
    wire sclk_s = ctl_s[0];
    wire ss_s = ctl_s[1];
    wire rd_s = ctl_s[2];
    wire wr_s = ctl_s[3];
    wire oen_s = ctl_s[4];

    logic sclk_p_q;
    logic rd_p_q;
    logic wr_p_q;
    wire sclk_rise = sclk_s & ~sclk_p_q;
    wire rd_fall = ~rd_s & rd_p_q;
    wire wr_fall = ~wr_s & wr_p_q;

    // mode selection
    logic [1:0] strap_q;
    logic strap_ok_q;
    logic [1:0] ctrl_q;
    ffsp_pkg::ffsp_mode_t mode_q;
    ffsp_pkg::ffsp_mode_t mode_d;
    wire strap_async = strap_ok_q && (strap_q == ffsp_pkg::NV_ASYNC);
    wire strap_flex = strap_ok_q && (strap_q == ffsp_pkg::NV_FLEX);
    wire sync_sel = ctrl_q[ffsp_pkg::CTRL_SYNC_POS];
    wire stat_en = ctrl_q[ffsp_pkg::CTRL_STEN_POS];
    // software may pick sync only on top of the async strap
    assign mode_d = strap_async ? (sync_sel ? ffsp_pkg::FFSP_MODE_SYNC :
                    ffsp_pkg::FFSP_MODE_ASYNC) :
                    strap_flex ? ffsp_pkg::FFSP_MODE_FLEX : ffsp_pkg::FFSP_MODE_OFF;
    wire m_sync = (mode_q == ffsp_pkg::FFSP_MODE_SYNC);
    wire m_async = (mode_q == ffsp_pkg::FFSP_MODE_ASYNC);
    wire m_flex = (mode_q == ffsp_pkg::FFSP_MODE_FLEX);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            strap_q <= ffsp_pkg::NV_OTHER;
            strap_ok_q <= 1'b0;
            mode_q <= ffsp_pkg::FFSP_MODE_OFF;
            sclk_p_q <= 1'b0;
            rd_p_q <= 1'b1;
            wr_p_q <= 1'b1;
        end else begin
            // strap caught once, first cycle after release
            if (!strap_ok_q) begin
                strap_q <= nv_mode;
                strap_ok_q <= 1'b1;
            end
            mode_q <= mode_d;
            sclk_p_q <= sclk_s;
            rd_p_q <= rd_s;
            wr_p_q <= wr_s;
        end
    end

    // fifo clock: fractional divider, average exactly 60 MHz, edges jitter by one cycle
    logic [8:0] facc_q;
    logic fclk_q;
    wire [8:0] facc_sum = facc_q + ffsp_pkg::FCLK_STEP;
    wire fclk_tog = (facc_sum >= ffsp_pkg::FCLK_WRAP);
    wire fclk_rise = m_sync & fclk_tog & ~fclk_q;
    assign fifo_clock_out = fclk_q;

    always_ff @(posedge clock) begin
        if (!rstn || !m_sync) begin
            facc_q <= 9'h000;
            fclk_q <= 1'b0;
        end else begin
            facc_q <= fclk_tog ? (facc_sum - ffsp_pkg::FCLK_WRAP) : facc_sum;
            if (fclk_tog) begin
                fclk_q <= ~fclk_q;
            end
        end
    end

    // parallel fifo handshakes
    logic rxf_q;
    logic txe_q;
    logic rxf_d;
    logic txe_d;
    // read needs enable low; write only while bus is not turned toward the master
    wire sync_pop = fclk_rise & ~rxf_q & ~rd_s & ~oen_s & rxb_valid;
    wire sync_push = fclk_rise & ~txe_q & ~wr_s & oen_s & txb_ready;
    wire async_pop = m_async & rd_fall & rxb_valid;
    wire async_push = m_async & wr_fall & txb_ready;
    assign rxf_d = m_sync ? (fclk_rise ? ~rxb_valid : rxf_q) :
                   m_async ? (~rxb_valid | ~rd_s) : 1'b1;
    assign txe_d = m_sync ? (fclk_rise ? ~txb_ready : txe_q) :
                   m_async ? (~txb_ready | ~wr_s) : 1'b1;
    assign rx_data_available_n = rxf_q;
    assign tx_space_available_n = txe_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rxf_q <= 1'b1;
            txe_q <= 1'b1;
        end else begin
            rxf_q <= rxf_d;
            txe_q <= txe_d;
        end
    end

    // flexible serial slave
    ffsp_pkg::ffsp_fst_t fst_q;
    logic [1:0] fwid_q;
    logic [7:0] fword_q;
    logic [2:0] fcnt_q;
    logic [7:0] fsh_q;
    logic [3:0] fcmd_q;
    logic frd_q;
    logic fack_q;
    logic fref_q;
    wire in_cmd = (fst_q == ffsp_pkg::FFSP_F_CMD);
    wire in_turn = (fst_q == ffsp_pkg::FFSP_F_TURN);
    wire in_data = (fst_q == ffsp_pkg::FFSP_F_DATA);
    // pulled-up unused lines read as one, so priority decode sees the real width
    wire [1:0] wid_dec = ~&dat_s[7:4] ? ffsp_pkg::W8 :
                         ~&dat_s[3:2] ? ffsp_pkg::W4 :
                         ~dat_s[1] ? ffsp_pkg::W2 : ffsp_pkg::W1;
    wire [1:0] cur_w = (in_cmd && fcnt_q == 3'h0) ? wid_dec : fwid_q;
    wire [7:0] lane_m = ffsp_lanes(cur_w);
    wire [2:0] slot_sh = 3'({1'b0, fcnt_q} << cur_w);
    wire [7:0] lanes_in = (dat_s & lane_m) << slot_sh;
    wire [7:0] word_full = fword_q | lanes_in;
    wire [3:0] cmd_full = {word_full[ffsp_pkg::CMD3_POS], word_full[ffsp_pkg::CMD2_POS],
                           word_full[ffsp_pkg::CMD1_POS], word_full[ffsp_pkg::CMD0_POS]};
    // 1-bit: bits 0..6 over seven clocks, the eighth turns the bus round
    wire cmd_last = (fcnt_q == (3'h6 >> cur_w));
    wire byte_last = (fcnt_q == (3'h7 >> fwid_q));
    wire fok = frd_q ? rxb_valid : ((fcmd_q == ffsp_pkg::CMD_WRITE) && txb_ready);
    wire fx_slot = m_flex & in_data & sclk_rise & byte_last & ~fref_q & fack_q;
    wire fx_push = fx_slot & ~frd_q & txb_ready;
    wire fx_pop = fx_slot & frd_q & rxb_valid;

    assign rxb_ready = sync_pop | async_pop | fx_pop;
    assign txb_valid = sync_push | async_push | fx_push;
    assign txb_data = m_flex ? (fsh_q | lanes_in) : dat_s;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            fst_q <= ffsp_pkg::FFSP_F_IDLE;
            fwid_q <= ffsp_pkg::W1;
            fword_q <= 8'h00;
            fcnt_q <= 3'h0;
            fsh_q <= 8'h00;
            fcmd_q <= 4'h0;
            frd_q <= 1'b0;
            fack_q <= 1'b0;
            fref_q <= 1'b0;
        end else if (ss_s || !m_flex) begin
            fst_q <= ffsp_pkg::FFSP_F_IDLE;
            fcnt_q <= 3'h0;
            fref_q <= 1'b0;
        end else begin
            unique case (fst_q)
                ffsp_pkg::FFSP_F_IDLE: begin
                    fst_q <= ffsp_pkg::FFSP_F_CMD;
                    fword_q <= 8'h00;
                    fcnt_q <= 3'h0;
                end
                ffsp_pkg::FFSP_F_CMD: begin
                    if (sclk_rise) begin
                        fword_q <= word_full;
                        if (fcnt_q == 3'h0) begin
                            fwid_q <= wid_dec;
                        end
                        if (cmd_last) begin
                            fst_q <= ffsp_pkg::FFSP_F_TURN;
                            fcmd_q <= cmd_full;
                        end else begin
                            fcnt_q <= fcnt_q + 3'h1;
                        end
                    end
                end
                ffsp_pkg::FFSP_F_TURN: begin
                    if (sclk_rise) begin
                        frd_q <= (fcmd_q == ffsp_pkg::CMD_READ);
                        fst_q <= ffsp_pkg::FFSP_F_DATA;
                        fcnt_q <= 3'h0;
                        fref_q <= 1'b1;
                    end
                end
                ffsp_pkg::FFSP_F_DATA: begin
                    // buffers settle one cycle after a pop or push, so ack is
                    // sampled then, well inside one serial clock period
                    if (fref_q) begin
                        fref_q <= 1'b0;
                        fack_q <= fok;
                        fsh_q <= frd_q ? rxb_data : 8'h00;
                    end else if (sclk_rise) begin
                        if (!frd_q) begin
                            fsh_q <= fsh_q | lanes_in;
                        end
                        if (byte_last) begin
                            fcnt_q <= 3'h0;
                            fref_q <= 1'b1;
                        end else begin
                            fcnt_q <= fcnt_q + 3'h1;
                        end
                    end
                end
                default: fst_q <= ffsp_pkg::FFSP_F_IDLE;
            endcase
        end
    end

    // pin drive
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic stl_q;
    logic stl_d;
    // async read keeps the byte taken at the strobe fall until the strobe rises
    wire async_hold = m_async & ~rd_s & ~rd_p_q;
    wire fidle_drv = m_flex & ss_s & stat_en;
    wire frd_drv = m_flex & ~ss_s & in_data & frd_q & fack_q;
    wire [7:0] flex_oe = frd_drv ? ffsp_lanes(fwid_q) : {7'h00, fidle_drv};
    // in the fifo modes the bus-direction pins follow the synchronised oe and read strobes
    assign bidir_data_lines_oe = m_sync ? {8{~oen_s}} :
                                 m_async ? {8{~rd_s}} :
                                 m_flex ? flex_oe : 8'h00;
    assign data_d = m_flex ? (ss_s ? {7'h00, ~txb_ready} : 8'(fsh_q >> slot_sh)) :
                    async_hold ? data_q : rxb_data;
    assign stl_d = in_data ? (fack_q ? ffsp_pkg::ACK_LVL : ffsp_pkg::NAK_LVL) : ~rxb_valid;
    assign bidir_data_lines_o = data_q;
    assign status_line_o = stl_q;
    assign status_line_oe = fidle_drv | (m_flex & ~ss_s & in_data);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            data_q <= 8'h00;
            stl_q <= 1'b1;
        end else begin
            data_q <= data_d;
            stl_q <= stl_d;
        end
    end

    // apb slave, zero wait states
    logic [31:0] prdata_q;
    logic [31:0] stat_word;
    wire hit_ctrl = (paddr == ffsp_pkg::CTRL_OFF);
    wire hit_stat = (paddr == ffsp_pkg::STAT_OFF);
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite & hit_ctrl;
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[ffsp_pkg::STAT_MODE_POS +: 4] = mode_q;
        stat_word[ffsp_pkg::STAT_WID_POS +: 2] = fwid_q;
        stat_word[ffsp_pkg::STAT_CMD_POS +: 4] = fcmd_q;
        stat_word[ffsp_pkg::STAT_SEL_POS] = ~ss_s;
        stat_word[ffsp_pkg::STAT_RXE_POS] = ~rxb_valid;
        stat_word[ffsp_pkg::STAT_TXF_POS] = ~txb_ready;
    end
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} : hit_stat ? stat_word : 32'h0000_0000;
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_ctrl | hit_stat);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl_q <= ffsp_pkg::CTRL_RST;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (apb_wr) begin
                ctrl_q <= pwdata[1:0];
            end
            if (apb_setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // checks
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    one_dir_a: assert property (!(rxb_ready && txb_valid))
        else $error("read and write taken together");
    sync_edge_a: assert property (m_sync && (rxb_ready || txb_valid) |=> $rose(fifo_clock_out))
        else $error("sync transfer off the clock rise");
    sync_clock_a: assert property (m_sync && $past(m_sync) |-> ##[1:2] $changed(fifo_clock_out))
        else $error("fifo clock stalled in sync mode");
    rxf_low_a: assert property (m_sync && fclk_rise && rxb_valid |=> !rx_data_available_n)
        else $error("rx available not shown");
    rxf_high_a: assert property (m_sync && fclk_rise && !rxb_valid |=> rx_data_available_n)
        else $error("rx available left low when empty");
    push_cond_a: assert property (m_sync && txb_valid |-> !tx_space_available_n && !wr_s)
        else $error("write taken without space and strobe");
    async_fall_a: assert property (m_async && rxb_ready |-> $past(rd_s) && !rd_s)
        else $error("async read not on strobe fall");
    async_noclk_a: assert property (!m_sync && $past(!m_sync) |-> !fifo_clock_out)
        else $error("fifo clock driven outside sync mode");
    idle_status_a: assert property (m_flex && ss_s && stat_en |-> bidir_data_lines_oe == 8'h01 && status_line_oe)
        else $error("deselected status not driven");
    status_off_a: assert property (m_flex && ss_s && !stat_en |-> bidir_data_lines_oe == 8'h00 && !status_line_oe)
        else $error("status driven while disabled");
    ack_drive_a: assert property (in_data && !ss_s |-> status_line_oe)
        else $error("ack line undriven in data phase");
    width_dec_a: assert property (m_flex && !ss_s && in_cmd && fcnt_q == 3'h0 && sclk_rise && !dat_s[4] |=> fwid_q == ffsp_pkg::W8)
        else $error("8-bit width not decoded");
    select_release_a: assert property (m_flex && !ss_s && !(in_data && frd_q) |-> bidir_data_lines_oe == 8'h00)
        else $error("bus driven while master owns it");
endmodule : ffsp_port

// ===== ffsp_host.sv
// external controller model for the fifo and serial pins
`timescale 1ns/1ps
module ffsp_host (
    input wire logic [7:0] dev_o,
    input wire logic [7:0] dev_oe,
    input wire logic st,
    output logic [7:0] bus,
    output logic rd_n,
    output logic wr_n,
    output logic oe_n,
    output logic sclk,
    output logic ss_n
);
    logic [7:0] drv_q = '0;
    logic [7:0] den_q = '0;
    logic [7:0] rdat;
    logic sel_oe;
    // pull-ups: a line nobody drives reads one
    assign bus = (dev_oe & dev_o) | (~dev_oe & den_q & drv_q) | (~dev_oe & ~den_q);
    initial begin
        rd_n = 1;
        wr_n = 1;
        oe_n = 1;
        sclk = 0;
        ss_n = 1;
    end
    // one strobe window; bus driven only when e is set
    task automatic hold(input logic o, input logic r, input logic w, input logic e,
                        input logic [7:0] d, input int t);
        // step off the system clock edge before touching any pin
        #1;
        drv_q = d;
        den_q = {8{e}};
        oe_n = o;
        #20;
        rd_n = r;
        wr_n = w;
        #t;
        rdat = bus;
        rd_n = 1;
        wr_n = 1;
        #20;
        oe_n = 1;
        den_q = '0;
    endtask : hold
    // one 1-bit frame: seven command rises, turnaround, eight data rises, or only one when the ack reads nak
    task automatic flex(input logic [3:0] cmd, input logic [7:0] wd, output logic [7:0] rd,
                        output logic ack);
        logic [7:0] cw;
        #1;
        cw = 8'hff;
        cw[0] = cmd[3];
        cw[3] = cmd[2];
        cw[5] = cmd[1];
        cw[6] = cmd[0];
        ss_n = 0;
        #80;
        sel_oe = dev_oe[0];
        den_q = 8'h01;
        for (int i = 0; i < 16; i++) begin
            if (i < 7) drv_q = {7'h7f, cw[i]};
            else if (i == 7 || cmd == ffsp_pkg::CMD_READ) den_q = '0;
            else begin
                den_q = 8'h01;
                drv_q = {7'h7f, wd[i-8]};
            end
            #80;
            if (i > 7) rd[i-8] = bus[0];
            sclk = 1;
            #80;
            sclk = 0;
            if (i == 8) ack = st;
            if (i == 8 && ack == ffsp_pkg::NAK_LVL) break;
        end
        den_q = '0;
        #80;
        ss_n = 1;
        #160;
    endtask : flex
endmodule : ffsp_host

// ===== ffsp_tb.sv
// self-checking bench for the fifo and flexible serial slave port
`timescale 1ns/1ps
module tb;
    logic clock = 0;
    logic rstn = 0;
    logic [11:0] paddr = '0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [31:0] pwdata = '0, prdata;
    logic [1:0] nv_mode = ffsp_pkg::NV_ASYNC;
    logic rxb_valid, rxb_ready, txb_valid, txb_ready = 1;
    logic [7:0] rxb_data = 8'h5a, txb_data, bus, dev_o, dev_oe, r8, h8;
    logic rxf_n, txe_n, rd_n, wr_n, oe_n, fclk, fclk_d = 0, sclk, ss_n, st_o, st_oe, a1;
    int failures = 0, checks_done = 0, cyc = 0, pops = 0, pushes = 0, rx_left = 0, rises = 0;
    logic [32:0] rdq[$];
    logic [7:0] txq[$];
    always #2.5 clock = ~clock;
    assign rxb_valid = rx_left != 0;
    ffsp_port u_ffsp_port (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nv_mode(nv_mode), .rxb_valid(rxb_valid),
        .rxb_data(rxb_data), .rxb_ready(rxb_ready), .txb_valid(txb_valid),
        .txb_data(txb_data), .txb_ready(txb_ready), .bidir_data_lines_i(bus),
        .bidir_data_lines_o(dev_o), .bidir_data_lines_oe(dev_oe),
        .rx_data_available_n(rxf_n), .tx_space_available_n(txe_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .output_enable_n(oe_n), .fifo_clock_out(fclk),
        .serial_clock(sclk), .slave_select_n(ss_n), .status_line_o(st_o),
        .status_line_oe(st_oe));
    ffsp_host u_ffsp_host (.dev_o(dev_o), .dev_oe(dev_oe), .st(st_o), .bus(bus),
        .rd_n(rd_n), .wr_n(wr_n), .oe_n(oe_n), .sclk(sclk), .ss_n(ss_n));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'($urandom);
        rdq.push_back(exp);
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic do_reset(input logic [1:0] m);
        @(posedge clock);
        rstn <= 0;
        nv_mode <= m;
        repeat (12) @(posedge clock);
        rstn <= 1;
        repeat (4) @(posedge clock);
    endtask : do_reset
    // result watcher: pushes, pops, fifo clock rises, apb answers
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
        fclk_d <= fclk;
        if (fclk && !fclk_d) rises++;
        if (rxb_ready) begin
            rx_left <= rx_left - 1;
            rxb_data <= 8'($urandom);
            pops++;
        end
        if (txb_valid) begin
            pushes++;
            if (txq.size() == 0) chk(txb_data, 33'h100);
            else chk(txb_data, txq.pop_front());
        end
        if (psel && penable && pready) begin
            if (pwrite) chk(pslverr, rdq[0][32]);
            else chk({pslverr, prdata}, rdq[0]);
            void'(rdq.pop_front());
        end
    end
    initial begin
        int p0;
        void'($urandom(80));
        do_reset(ffsp_pkg::NV_ASYNC);
        rx_left <= 4;
        apb(0, ffsp_pkg::CTRL_OFF, 0, {31'h0, ffsp_pkg::CTRL_RST});
        apb(0, ffsp_pkg::STAT_OFF, 0, 33'h2);
        apb(1, 12'h010, 32'hffff_ffff, 33'h1_0000_0000);
        apb(0, 12'h010, 0, 33'h1_0000_0000);
        apb(1, ffsp_pkg::STAT_OFF, 32'hffff_ffff, 33'h0);
        apb(0, ffsp_pkg::STAT_OFF, 0, 33'h2);
        h8 = rxb_data;
        u_ffsp_host.hold(1, 0, 1, 0, 0, 60);
        chk(u_ffsp_host.rdat, h8);
        r8 = 8'($urandom);
        txq.push_back(r8);
        u_ffsp_host.hold(0, 1, 0, 1, r8, 60);
        chk(fclk, 0);
        @(posedge clock);
        txb_ready <= 0;
        u_ffsp_host.hold(0, 1, 0, 1, 8'h33, 60);
        chk(txe_n, 1);
        @(posedge clock);
        txb_ready <= 1;
        apb(1, ffsp_pkg::CTRL_OFF, 32'h3, 0);
        apb(0, ffsp_pkg::STAT_OFF, 0, 33'h4);
        rises = 0;
        repeat (400) @(posedge clock);
        chk(rises >= 118 && rises <= 122, 1);
        rx_left <= 3;
        repeat (20) @(posedge clock);
        chk(rxf_n, 0);
        p0 = pops;
        u_ffsp_host.hold(0, 0, 0, 0, 0, 700);
        chk(pops - p0, 3);
        chk(rxf_n, 1);
        for (int i = 0; i < 16; i++) txq.push_back(8'hc3);
        p0 = pushes;
        u_ffsp_host.hold(1, 1, 0, 1, 8'hc3, 200);
        chk(pushes - p0 >= 10 && pushes - p0 <= 13, 1);
        txq.delete();
        rx_left <= 2;
        do_reset(ffsp_pkg::NV_FLEX);
        repeat (8) @(posedge clock);
        chk({bus[0], st_o, st_oe}, 3'b001);
        r8 = 8'($urandom);
        txq.push_back(r8);
        u_ffsp_host.flex(ffsp_pkg::CMD_WRITE, r8, h8, a1);
        chk(a1, ffsp_pkg::ACK_LVL);
        chk(u_ffsp_host.sel_oe, 0);
        r8 = rxb_data;
        u_ffsp_host.flex(ffsp_pkg::CMD_READ, 0, h8, a1);
        chk({a1, h8}, {ffsp_pkg::ACK_LVL, r8});
        u_ffsp_host.flex(4'h5, 8'h81, h8, a1);
        chk(a1, ffsp_pkg::NAK_LVL);
        apb(0, ffsp_pkg::STAT_OFF, 0, 33'h148);
        apb(1, ffsp_pkg::CTRL_OFF, 32'h0, 0);
        repeat (8) @(posedge clock);
        chk({bus[0], st_oe}, 2'b10);
        stop_test();
    end
endmodule : tb
